// *** hdl/gcio_pkg.sv ***
package gcio_pkg;
  // Basic geometry
  localparam int NUM_CUST = 4;
  localparam int CFG_NIB = 4;
  localparam int CFG_W = NUM_CUST * CFG_NIB;
  localparam int LBL_LEN = 19;
  localparam int SEL_W = 2;
  localparam int MSG_W = 4;

  // Bit positions in the contact vector (asserted = 1 after inversion)
  localparam int IN_REM_START = 0;
  localparam int IN_REM_ESTOP = 1;
  localparam int IN_REM_RESET = 2;
  localparam int IN_CUST = 3;
  localparam int IN_PNL_ESTOP = 7;
  localparam int IN_ACK = 8;
  localparam int IN_LAMP = 9;
  localparam int IN_MAN_RUN = 10;
  localparam int IN_MENU = 11;
  localparam int NUM_MENU = 4;
  localparam int IN_SEL = 15;
  localparam int IN_W = 17;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEBOUNCE_US = 10;
  localparam int DB_CNT_W = 12;
  localparam logic [DB_CNT_W-1:0] DEBOUNCE_CYCLES = DB_CNT_W'(DEBOUNCE_US * 1000 / CLK_PERIOD_NS);
  localparam int SCRSAVER_MIN = 30;
  localparam int TMR_W = 40;
  localparam logic [TMR_W-1:0] SCRSAVER_CYCLES =
    TMR_W'(longint'(SCRSAVER_MIN) * 64'd60_000_000_000 / CLK_PERIOD_NS);

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IN_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OUT_CFG = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_LBL_SEL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_LBL_DATA = 8'h14;

  // Field layouts
  localparam int CTRL_SLEEP_EN = 0;
  localparam int NIB_EN = 0;
  localparam int NIB_SEV = 1;
  localparam int NIB_POL = 3;
  localparam int NIB_EV = 1;
  localparam int LBL_CHR_LSB = 0;
  localparam int LBL_CHR_W = 5;
  localparam int LBL_IN_LSB = 8;
  localparam int ST_WARN = 0;
  localparam int ST_SHUT = 4;
  localparam int ST_STAT = 8;
  localparam int ST_ESTOP = 12;
  localparam int ST_SLEEP = 13;
  localparam int ST_DISP = 14;
  localparam int ST_CFG_ERR = 15;
  localparam int ST_RUN = 16;

  // Reset values
  localparam logic [CFG_W-1:0] IN_CFG_RST = 16'h5551;
  localparam logic [CFG_W-1:0] OUT_CFG_RST = 16'h7531;
  localparam logic [7:0] CHR_BLANK = 8'h20;
  localparam logic [NUM_CUST-1:0][LBL_LEN-1:0][7:0] LBL_RST = {
    "Rupture Basin Fault", "Low Fuel           ", "Ground Fault       ", "Customer Fault 1   "};

  // Display message codes
  localparam logic [MSG_W-1:0] MSG_NONE = 4'h0;
  localparam logic [MSG_W-1:0] MSG_WARN = 4'h1;
  localparam logic [MSG_W-1:0] MSG_SHUT = 4'h5;
  localparam logic [MSG_W-1:0] MSG_ESTOP = 4'h9;

  typedef enum logic [1:0] {SEV_NONE, SEV_STATUS, SEV_WARN, SEV_SHUT} gcio_sev_type;
  typedef enum logic [SEL_W-1:0] {SEL_OFF, SEL_MANUAL, SEL_AUTO} gcio_sel_type;
  typedef enum logic [2:0] {EV_COM_WARN, EV_COM_SHUT, EV_NOT_AUTO, EV_READY_LOAD, EV_RUNNING,
    EV_REM_START} gcio_ev_type;
  localparam int NUM_EV = 6;

  // Nibble of a per-channel configuration word
  function automatic logic [CFG_NIB-1:0] cfg_nib(input logic [CFG_W-1:0] cfg, input int i);
    return cfg[i*CFG_NIB +: CFG_NIB];
  endfunction

  // Character k is stored from the top byte down
  function automatic logic [LBL_CHR_W-1:0] lbl_pos(input logic [LBL_CHR_W-1:0] k);
    return LBL_CHR_W'(LBL_LEN - 1) - k;
  endfunction

  // Byte-lane merge for bus writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// *** hdl/gcio_db_if.sv ***
`timescale 1ns/100ps
// Raw contact levels in, clean levels out
interface gcio_db_if;
  logic [gcio_pkg::IN_W-1:0] raw;
  logic [gcio_pkg::IN_W-1:0] clean;
  modport filt(input raw, output clean);
  modport user(output raw, input clean);
endinterface

// *** hdl/gcio_debounce.sv ***
`timescale 1ns/100ps
module gcio_debounce (
  input wire logic i_clk,
  input wire logic i_rst_n,
  gcio_db_if.filt dbi
);
  import gcio_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] stable;
    logic [IN_W-1:0][DB_CNT_W-1:0] cnt;
  } gcio_db_state_type;

  gcio_db_state_type s_q;
  gcio_db_state_type s_d;

  // Two-stage synchroniser, then a level must hold for the full window before it is passed on
  always_comb begin
    s_d = s_q;
    s_d.s1 = dbi.raw;
    s_d.s2 = s_q.s1;
    for (int i = 0; i < IN_W; i++) begin
      if (s_q.s2[i] == s_q.stable[i]) begin
        s_d.cnt[i] = '0;
      end else if (s_q.cnt[i] == DEBOUNCE_CYCLES - 1'b1) begin
        s_d.stable[i] = s_q.s2[i];
        s_d.cnt[i] = '0;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 1'b1;
      end
    end
  end

  // Reset leaves every contact released and the selector at Off
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dbi.clean = s_q.stable;
endmodule

// *** hdl/gcio_core.sv ***
// What this block does
// - In Auto, grounded remote start begins the crank and start sequence.
// - Remote reset cannot clear a shutdown while remote start stays grounded.
// - Remote emergency stop shuts down at once; only the panel clears it.
// - Auto with start open: remote reset clears all faults except emergency stop.
// - Each asserted customer fault input runs its configured warning or shutdown.
// - Each customer input has its own enable; all four enabled at reset.
// - Severity status, warning or shutdown; input 1 none, inputs 2-4 warning.
// - Active polarity per input, closed or open; all default closed to ground.
// - Each input has a label of up to 19 characters shown with its fault.
// - Four output relays, normally open, close when their chosen condition holds.
// - Each output relay has its own enable; all four enabled at reset.
// - Relay events: 1 common warning, 2 common shutdown, 3 not Auto, 4 ready.
// - Switched supply is on exactly while a run command is held.
// - Display power drops after 30 minutes idle, running or not.
// - Any button, switch or input change restarts the 30 minute timer.
// - Indicator lamps keep working while the display is blanked.
// - A detected warning puts its message on the display.
// - In sleep the logic idles and all lamps and the display are off.
// - With sleep enabled, sleep once no faults remain and selector is Off; sleep also waits for the idle timeout.
// - Selector, emergency stop, acknowledge or lamp button wakes and reinitialises.
// - Sleep is disabled at reset; disabled means always awake.
// - Sleep enabled with network or transfer installed is an error; only network installed is flagged.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module gcio_core #(
  parameter logic [gcio_pkg::TMR_W-1:0] P_SCRSAVER_CYCLES = gcio_pkg::SCRSAVER_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic [gcio_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_REMOTE_START_N,
  input wire logic I_REMOTE_ESTOP_N,
  input wire logic I_REMOTE_RESET_N,
  input wire logic [gcio_pkg::NUM_CUST-1:0] I_CUST_FAULT_N,
  input wire logic I_PANEL_ESTOP_N,
  input wire logic I_FAULT_ACK_N,
  input wire logic I_LAMP_BTN_N,
  input wire logic I_MANUAL_RUN_N,
  input wire logic [gcio_pkg::NUM_MENU-1:0] I_MENU_BTN_N,
  input wire logic [gcio_pkg::SEL_W-1:0] I_SEL_MODE,
  input wire logic I_ENGINE_RUNNING,
  input wire logic I_READY_TO_LOAD,
  input wire logic I_NET_INSTALLED,
  input wire logic [gcio_pkg::LBL_CHR_W-1:0] I_LBL_CHAR_SEL,
  output logic O_RUN_CMD,
  output logic O_SWITCHED_SUPPLY,
  output logic [gcio_pkg::NUM_CUST-1:0] O_CUST_RELAY,
  output logic O_LAMP_WARN,
  output logic O_LAMP_SHUTDOWN,
  output logic O_LAMP_RUNNING,
  output logic O_LAMP_REMOTE_START,
  output logic O_LAMP_NOT_AUTO,
  output logic O_DISP_PWR,
  output logic [gcio_pkg::MSG_W-1:0] O_DISP_MSG,
  output logic [7:0] O_DISP_CHAR,
  output logic O_SLEEP,
  output logic O_CFG_ERR
);
  import gcio_pkg::*;

  typedef struct packed {
    logic sleep_en;
    logic [CFG_W-1:0] in_cfg;
    logic [CFG_W-1:0] out_cfg;
    logic [1:0] lbl_in;
    logic [LBL_CHR_W-1:0] lbl_chr;
    logic [NUM_CUST-1:0][LBL_LEN-1:0][7:0] lbl;
    logic [NUM_CUST-1:0] warn;
    logic [NUM_CUST-1:0] shut;
    logic [NUM_CUST-1:0] stat;
    logic estop;
    logic run;
    logic sleeping;
    logic [TMR_W-1:0] tmr;
    logic [IN_W-1:0] prev;
    logic waitreq;
    logic [31:0] rdata;
    logic [NUM_CUST-1:0] relay;
    logic [4:0] lamp;
    logic disp;
    logic [MSG_W-1:0] msg;
    logic [7:0] chr;
    logic err;
  } gcio_core_state_type;

  localparam gcio_core_state_type STATE_RST = '{
    sleep_en: 1'b0,
    in_cfg: IN_CFG_RST,
    out_cfg: OUT_CFG_RST,
    lbl: LBL_RST,
    waitreq: 1'b1,
    disp: 1'b1,
    default: '0
  };

  gcio_core_state_type s_q;
  gcio_core_state_type s_d;
  gcio_db_if dbi();

  logic [IN_W-1:0] clean;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] chg;
  gcio_sel_type sel;
  logic is_auto;
  logic is_off;
  logic wake;
  logic cfg_err;
  logic ack_off;
  logic reset_ok;
  logic [NUM_CUST-1:0] act;

  // Contacts are grounded to assert, so invert before filtering
  assign dbi.raw = {I_SEL_MODE, ~I_MENU_BTN_N, ~I_MANUAL_RUN_N, ~I_LAMP_BTN_N, ~I_FAULT_ACK_N,
    ~I_PANEL_ESTOP_N, ~I_CUST_FAULT_N, ~I_REMOTE_RESET_N, ~I_REMOTE_ESTOP_N, ~I_REMOTE_START_N};

  gcio_debounce u_debounce (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .dbi(dbi.filt)
  );

  // Edges of the clean contacts drive acknowledge, reset, wake, manual run and timer events; faults, stops and auto run use levels
  assign clean = dbi.clean;
  assign rise = clean & ~s_q.prev;
  assign chg = clean ^ s_q.prev;
  assign sel = gcio_sel_type'(clean[IN_SEL +: SEL_W]);
  assign is_auto = sel == SEL_AUTO;
  assign is_off = !is_auto && sel != SEL_MANUAL; // Unused selector code is treated as Off for safety
  assign wake = (|chg[IN_SEL +: SEL_W]) | rise[IN_REM_ESTOP] | rise[IN_PNL_ESTOP] |
    rise[IN_ACK] | rise[IN_LAMP];
  assign cfg_err = s_q.sleep_en && I_NET_INSTALLED;
  assign ack_off = rise[IN_ACK] && is_off;
  assign reset_ok = rise[IN_REM_RESET] && is_auto && !clean[IN_REM_START];

  // Per-input enable and polarity; open-active inputs assert when the contact lifts
  for (genvar g = 0; g < NUM_CUST; g++) begin : g_act
    assign act[g] = s_q.in_cfg[g*CFG_NIB + NIB_EN] &&
      (clean[IN_CUST + g] ^ s_q.in_cfg[g*CFG_NIB + NIB_POL]);
  end

  // Whole next state: bus slave, fault latches, run, timer, sleep and registered outputs
  always_comb begin
    logic [CFG_NIB-1:0] nib;
    logic [NUM_CUST-1:0] wset;
    logic [NUM_CUST-1:0] sset;
    logic [NUM_EV-1:0] ev;
    logic any_shut;
    logic expired;
    logic [31:0] wv;
    nib = '0;
    wset = '0;
    sset = '0;
    ev = '0;
    any_shut = 1'b0;
    expired = 1'b0;
    wv = '0;
    s_d = s_q;
    s_d.prev = clean;
    s_d.waitreq = 1'b1;

    // Bus: first edge of a request drops waitrequest and loads read data, the second commits
    if ((I_AVS_READ || I_AVS_WRITE) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = '0;
      if (I_AVS_READ) begin
        unique case (I_AVS_ADDRESS)
          REG_CTRL: s_d.rdata[CTRL_SLEEP_EN] = s_q.sleep_en;
          REG_IN_CFG: s_d.rdata[CFG_W-1:0] = s_q.in_cfg;
          REG_OUT_CFG: s_d.rdata[CFG_W-1:0] = s_q.out_cfg;
          REG_STATUS: begin
            s_d.rdata[ST_WARN +: NUM_CUST] = s_q.warn;
            s_d.rdata[ST_SHUT +: NUM_CUST] = s_q.shut;
            s_d.rdata[ST_STAT +: NUM_CUST] = s_q.stat;
            s_d.rdata[ST_ESTOP] = s_q.estop;
            s_d.rdata[ST_SLEEP] = s_q.sleeping;
            s_d.rdata[ST_DISP] = s_q.disp;
            s_d.rdata[ST_CFG_ERR] = s_q.err;
            s_d.rdata[ST_RUN] = s_q.run;
          end
          REG_LBL_SEL: begin
            s_d.rdata[LBL_CHR_LSB +: LBL_CHR_W] = s_q.lbl_chr;
            s_d.rdata[LBL_IN_LSB +: 2] = s_q.lbl_in;
          end
          REG_LBL_DATA: begin
            if (s_q.lbl_chr < LBL_CHR_W'(LBL_LEN)) begin
              s_d.rdata[7:0] = s_q.lbl[s_q.lbl_in][lbl_pos(s_q.lbl_chr)];
            end
          end
          default: s_d.rdata = '0; // Unmapped reads return zero
        endcase
      end
    end else if (I_AVS_WRITE && !s_q.waitreq) begin
      unique case (I_AVS_ADDRESS)
        REG_CTRL: begin
          wv = be_merge({31'h0, s_q.sleep_en}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          s_d.sleep_en = wv[CTRL_SLEEP_EN];
        end
        REG_IN_CFG: begin
          wv = be_merge({16'h0, s_q.in_cfg}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          s_d.in_cfg = wv[CFG_W-1:0];
        end
        REG_OUT_CFG: begin
          wv = be_merge({16'h0, s_q.out_cfg}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          s_d.out_cfg = wv[CFG_W-1:0];
        end
        REG_LBL_SEL: begin
          wv = be_merge({22'h0, s_q.lbl_in, 3'h0, s_q.lbl_chr}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
          s_d.lbl_chr = wv[LBL_CHR_LSB +: LBL_CHR_W];
          s_d.lbl_in = wv[LBL_IN_LSB +: 2];
        end
        REG_LBL_DATA: begin
          if (I_AVS_BYTEENABLE[0] && s_q.lbl_chr < LBL_CHR_W'(LBL_LEN)) begin
            s_d.lbl[s_q.lbl_in][lbl_pos(s_q.lbl_chr)] = I_AVS_WRITEDATA[7:0];
          end
        end
        default: s_d.sleep_en = s_q.sleep_en; // Unmapped and read-only writes are dropped
      endcase
    end

    if (s_q.sleeping) begin
      // Sleeping logic only watches for a wake source
      if (wake) begin
        s_d.sleeping = 1'b0;
        s_d.tmr = '0;
      end
    end else begin
      // Classify each active input by its configured severity
      for (int i = 0; i < NUM_CUST; i++) begin
        nib = cfg_nib(s_q.in_cfg, i);
        wset[i] = act[i] && gcio_sev_type'(nib[NIB_SEV +: 2]) == SEV_WARN;
        sset[i] = act[i] && gcio_sev_type'(nib[NIB_SEV +: 2]) == SEV_SHUT;
        s_d.stat[i] = act[i] && gcio_sev_type'(nib[NIB_SEV +: 2]) == SEV_STATUS;
      end
      // A fault still present re-latches in the same cycle as a clear
      s_d.warn = (s_q.warn & ~{NUM_CUST{rise[IN_ACK] || reset_ok}}) | wset;
      s_d.shut = (s_q.shut & ~{NUM_CUST{ack_off || reset_ok}}) | sset;
      // Emergency stop ignores the remote reset; only the panel acknowledge in Off releases it
      s_d.estop = (s_q.estop && !ack_off) || clean[IN_REM_ESTOP] || clean[IN_PNL_ESTOP];
      any_shut = (|s_d.shut) || s_d.estop;

      // Run command
      if (any_shut || is_off) begin
        s_d.run = 1'b0;
      end else if (is_auto) begin
        s_d.run = clean[IN_REM_START];
      end else if (rise[IN_MAN_RUN]) begin
        s_d.run = !s_q.run;
      end

      // Idle timer; any contact or button change restarts it
      if (|chg) begin
        s_d.tmr = '0;
      end else if (s_q.tmr != P_SCRSAVER_CYCLES) begin
        s_d.tmr = s_q.tmr + 1'b1;
      end
      expired = s_d.tmr == P_SCRSAVER_CYCLES;

      // Sleep waits for the display to blank so a wake is not undone on the next edge
      if (s_q.sleep_en && !cfg_err && is_off && !any_shut && !(|s_d.warn) && expired) begin
        s_d.sleeping = 1'b1;
      end
    end

    // Registered outputs
    expired = s_d.tmr == P_SCRSAVER_CYCLES;
    any_shut = (|s_d.shut) || s_d.estop;
    s_d.disp = !expired && !s_d.sleeping;
    s_d.err = cfg_err;
    s_d.lamp = s_d.sleeping ? 5'h00 : {!is_auto, clean[IN_REM_START], I_ENGINE_RUNNING, any_shut,
      |s_d.warn};
    ev = {clean[IN_REM_START], I_ENGINE_RUNNING, I_READY_TO_LOAD, !is_auto, any_shut, |s_d.warn};
    for (int i = 0; i < NUM_CUST; i++) begin
      nib = cfg_nib(s_q.out_cfg, i);
      s_d.relay[i] = nib[NIB_EN] && nib[NIB_EV +: 3] < 3'(NUM_EV) && ev[nib[NIB_EV +: 3]];
    end
    // Most severe fault owns the display, lowest input first
    s_d.msg = MSG_NONE;
    for (int i = NUM_CUST - 1; i >= 0; i--) begin
      if (s_d.warn[i]) begin
        s_d.msg = MSG_WARN + MSG_W'(i);
      end
    end
    for (int i = NUM_CUST - 1; i >= 0; i--) begin
      if (s_d.shut[i]) begin
        s_d.msg = MSG_SHUT + MSG_W'(i);
      end
    end
    if (s_d.estop) begin
      s_d.msg = MSG_ESTOP;
    end
    s_d.chr = CHR_BLANK;
    if (s_d.msg != MSG_NONE && s_d.msg != MSG_ESTOP && I_LBL_CHAR_SEL < LBL_CHR_W'(LBL_LEN)) begin
      s_d.chr = s_q.lbl[2'(s_d.msg - MSG_WARN)][lbl_pos(I_LBL_CHAR_SEL)];
    end
  end

  // Single state register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_AVS_READDATA = s_q.rdata;
  assign O_AVS_WAITREQUEST = s_q.waitreq;
  assign O_RUN_CMD = s_q.run;
  assign O_SWITCHED_SUPPLY = s_q.run;
  assign O_CUST_RELAY = s_q.relay;
  assign {O_LAMP_NOT_AUTO, O_LAMP_REMOTE_START, O_LAMP_RUNNING, O_LAMP_SHUTDOWN, O_LAMP_WARN} = s_q.lamp;
  assign O_DISP_PWR = s_q.disp;
  assign O_DISP_MSG = s_q.msg;
  assign O_DISP_CHAR = s_q.chr;
  assign O_SLEEP = s_q.sleeping;
  assign O_CFG_ERR = s_q.err;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  AST_AUTO_START: assert property ((!s_q.sleeping && is_auto && clean[IN_REM_START] && !s_q.estop &&
    !clean[IN_REM_ESTOP] && !clean[IN_PNL_ESTOP] && s_d.shut == '0) |=> O_RUN_CMD)
    else $error("remote start in auto did not raise run");
  AST_RESET_BLOCKED: assert property ((!s_q.sleeping && s_q.shut != '0 &&
    clean[IN_REM_START] && !ack_off) |=> (s_q.shut & $past(s_q.shut)) == $past(s_q.shut))
    else $error("shutdown cleared while remote start grounded");
  AST_ESTOP_STOP: assert property ((!s_q.sleeping && clean[IN_REM_ESTOP]) |=> s_q.estop && !O_RUN_CMD)
    else $error("remote emergency stop did not shut down");
  AST_ESTOP_HOLD: assert property ((s_q.estop && !(ack_off && !s_q.sleeping)) |=> s_q.estop)
    else $error("emergency stop released without panel acknowledge");
  AST_REMOTE_RESET: assert property ((!s_q.sleeping && reset_ok && act == '0) |=>
    s_q.warn == '0 && s_q.shut == '0 && s_q.estop == $past(s_q.estop || clean[IN_REM_ESTOP] || clean[IN_PNL_ESTOP]))
    else $error("remote reset did not clear faults");
  AST_SUPPLY_OFF: assert property ((!s_q.sleeping && is_off) |=>
    !O_SWITCHED_SUPPLY ##1 O_SWITCHED_SUPPLY == O_RUN_CMD)
    else $error("switched supply on without run command");
  AST_BLANK: assert property ((s_q.tmr == P_SCRSAVER_CYCLES) |-> !O_DISP_PWR)
    else $error("display powered after idle timeout");
  AST_TMR_RESTART: assert property ((!s_q.sleeping && chg != '0) |=> s_q.tmr == '0 && O_DISP_PWR)
    else $error("activity did not restart the idle timer");
  AST_SLEEP_DARK: assert property (s_q.sleeping |-> s_q.lamp == '0 && !O_DISP_PWR && !O_LAMP_WARN)
    else $error("lamps or display on during sleep");
  AST_NO_SLEEP: assert property ((!s_q.sleeping && (!s_q.sleep_en || cfg_err)) |=> !O_SLEEP)
    else $error("entered sleep while sleep is unavailable");
  AST_WAKE: assert property ((s_q.sleeping && wake) |=> !s_q.sleeping && s_q.tmr == '0)
    else $error("wake source did not wake the controller");
  AST_BUS_ONE_WAIT: assert property (((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST) |=> !O_AVS_WAITREQUEST)
    else $error("bus answer later than one cycle");

  COV_SLEEP: cover property (!s_q.sleeping ##1 s_q.sleeping);
  COV_ESTOP_CLEAR: cover property (s_q.estop ##1 !s_q.estop);
  COV_RELAY: cover property (O_CUST_RELAY != '0);
  COV_AUTO_RUN: cover property (is_auto && O_RUN_CMD);
endmodule

// *** dv/gcio_contacts.sv ***
`timescale 1ns/100ps
// Remote switches and panel contacts: closed pulls the line low, open lets the pull-up win
module gcio_contacts (
  input wire logic i_clk,
  input wire logic [9:0] i_close,
  output logic [9:0] o_line_n
);
  logic [9:0] last = 10'h000;
  logic [9:0] chg = 10'h000;
  logic [2:0] cnt = 3'h0;
  initial o_line_n = 10'h3ff;
  // Every move chatters for six cycles, so a filter that trusts the first edge sees extra events
  always @(posedge i_clk) begin
    if (i_close != last) begin
      chg <= i_close ^ last;
      cnt <= 3'h6;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
    last <= i_close;
    o_line_n <= (cnt != 3'h0) ? (o_line_n ^ chg) : ~last;
  end
endmodule

// *** dv/gcio_core_tb.sv ***
`timescale 1ns/100ps
module gcio_core_tb;
  import gcio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [1:0] sel = 2'h0;
  logic net = 1'b0;
  logic rdy = 1'b0;
  logic [4:0] lc = 5'h00;
  logic chk = 1'b0;
  logic [9:0] cl = 10'h000;
  logic [9:0] ln;
  logic [31:0] rdat;
  logic [63:0] le;
  logic wreq, run, sup, lw, ls, dp, slp, err, na, rs, rn;
  logic [7:0] dch;
  logic [3:0] relay, msg;
  logic [31:0] rq[$];
  logic [63:0] lq[$];
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h64b8d383;
  wire logic [31:0] obs = {dch, 5'h00, na, rs, rn, run, sup, relay, lw, ls, dp, slp, err, 1'b0, msg};

  always #2 clk = ~clk;

  gcio_contacts i_sw (.i_clk(clk), .i_close(cl), .o_line_n(ln));

  // Screen saver cut to 200 cycles so idle blanking fits between contact moves
  gcio_core #(.P_SCRSAVER_CYCLES(40'd200)) i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_REMOTE_START_N(ln[0]), .I_REMOTE_ESTOP_N(ln[1]),
    .I_REMOTE_RESET_N(ln[2]), .I_CUST_FAULT_N(ln[6:3]), .I_PANEL_ESTOP_N(ln[7]), .I_FAULT_ACK_N(ln[8]),
    .I_LAMP_BTN_N(ln[9]), .I_MANUAL_RUN_N(1'b1), .I_MENU_BTN_N(4'hf), .I_SEL_MODE(sel),
    .I_ENGINE_RUNNING(1'b0), .I_READY_TO_LOAD(rdy), .I_NET_INSTALLED(net), .I_LBL_CHAR_SEL(lc),
    .O_RUN_CMD(run), .O_SWITCHED_SUPPLY(sup), .O_CUST_RELAY(relay), .O_LAMP_WARN(lw),
    .O_LAMP_SHUTDOWN(ls), .O_LAMP_RUNNING(rn), .O_LAMP_REMOTE_START(rs), .O_LAMP_NOT_AUTO(na),
    .O_DISP_PWR(dp), .O_DISP_MSG(msg), .O_DISP_CHAR(dch), .O_SLEEP(slp), .O_CFG_ERR(err));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic stop_test;
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low; the bench timeout ends a hung wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  // Note of masked output levels, taken by the monitor two edges later
  task automatic lv(input logic [31:0] m, input logic [31:0] v);
    lq.push_back({m, v});
    @(posedge clk);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Monitor: each result that appears is matched to the oldest note
  always @(posedge clk) begin
    cyc++;
    if (rd && wreq === 1'b0) begin
      cmp("readdata", rq.pop_front(), rdat);
    end
    if (chk) begin
      le = lq.pop_front();
      cmp("outputs", le[31:0], le[63:32] & obs);
    end
    if (cyc == 80000) begin
      errors++;
      stop_test();
    end
  end

  // Contact moves wait out the 2500-cycle filter plus bounce before levels are judged
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdx(REG_CTRL, 32'h0);
    rdx(REG_IN_CFG, 32'h5551);
    rdx(REG_OUT_CFG, 32'h7531);
    rdx(8'h20, 32'h0);
    seed = xs(seed);
    bus(1'b1, REG_IN_CFG, seed & 32'h0000eeee, 4'h3);
    rdx(REG_IN_CFG, {16'h0, seed[15:0] & 16'heeee});
    // Rename input 2 so the display check below proves the label path end to end
    bus(1'b1, REG_LBL_SEL, 32'h00000100, 4'hf);
    rdx(REG_LBL_DATA, 32'h00000047);
    bus(1'b1, REG_LBL_DATA, 32'h00000067, 4'h1);
    rdx(REG_LBL_DATA, 32'h00000067);
    bus(1'b1, REG_IN_CFG, 32'h5557, 4'hf);
    sel <= 2'h2;
    cl[0] <= 1'b1;
    rdy <= 1'b1;
    settle(2800);
    lv(32'h0007f300, 32'h0002e000);
    cl[4] <= 1'b1;
    settle(2800);
    lv(32'hff00860f, 32'h67008602);
    cl[3] <= 1'b1;
    lc <= 5'h01;
    settle(2800);
    lv(32'hff008b8f, 32'h75000b05);
    cl[4:3] <= 2'b00;
    settle(2800);
    cl[2] <= 1'b1;
    settle(2800);
    lv(32'h00000100, 32'h00000100);
    cl[2] <= 1'b0;
    cl[0] <= 1'b0;
    settle(2800);
    cl[2] <= 1'b1;
    settle(2800);
    lv(32'h00008f00, 32'h00000000);
    // Input 3 made active-open while its contact is open, so it asserts with no contact move
    bus(1'b1, REG_IN_CFG, 32'h5d57, 4'hf);
    settle(4);
    lv(32'h0000060f, 32'h00000603);
    bus(1'b1, REG_IN_CFG, 32'h5557, 4'hf);
    cl[2] <= 1'b0;
    cl[1] <= 1'b1;
    settle(2800);
    lv(32'hff00800f, 32'h20000009);
    rdx(REG_STATUS, 32'h00001004);
    cl[1] <= 1'b0;
    settle(2800);
    cl[2] <= 1'b1;
    settle(2800);
    lv(32'h0000000f, 32'h00000009);
    cl[2] <= 1'b0;
    sel <= 2'h0;
    settle(2800);
    cl[8] <= 1'b1;
    settle(2600);
    lv(32'h0004118f, 32'h00041080);
    cl[8] <= 1'b0;
    settle(2800);
    bus(1'b1, REG_CTRL, 32'h1, 4'hf);
    settle(300);
    lv(32'h000703c0, 32'h00000040);
    cl[9] <= 1'b1;
    settle(2600);
    lv(32'h000400c0, 32'h00040080);
    net <= 1'b1;
    settle(4);
    lv(32'h00000020, 32'h00000020);
    settle(2);
    stop_test();
  end
endmodule
